// *** verilog/spu_regs.svh ***
// Notes on behaviour
// - as master drive master-out; as slave it is an input.
// - data moves msb first; master-out carries shift register top bit.
// - slave-out floats when disabled or 4-wire slave not selected.
// - 3-wire slave drives slave-out from shift register top bit always.
// - master generates serial clock; slave receives it as input.
// - 4-wire slave ignores serial clock while select is high.
// - select mode 00: 3-wire, select unused, slave always selected.
// - select mode 01: select is input; low select enables slave.
// - mode 01 master: falling select edge clears master enable.
// - mode 1x: select pin driven at low bit level, as master or as slave.
// - select pin routed only in 4-wire modes.
// - master enable bit is bit 6 of control register.
// - data write loads transmit buffer; empty shifter starts transfer.
// - master shifts out at once while supplying serial clock.
// - transfer done flag, bit 7 of control, set at end.
// - enabled interrupts raise request when done flag sets.
`ifndef SPU_REGS_SVH
`define SPU_REGS_SVH
`define SPU_ADDR_CTRL    4'h0
`define SPU_ADDR_DATA    4'h4
`define SPU_ADDR_CLKDIV  4'h8
`define SPU_ADDR_STAT    4'hC
`define SPU_BIT_DONE     7
`define SPU_BIT_MASTER_ENABLE_BIT    6
`define SPU_BIT_MODEERR  5
`define SPU_BIT_ENABLE   0
`define SPU_CTRL_RESET   8'h04
`define SPU_CLKDIV_RESET 8'h01
`define SPU_BITS         4'h8
`define SPU_ADDR_IRQST   5'h10
`define SPU_ADDR_IRQEN   5'h14
`define SPU_ADDR_IRQCLR  5'h18
`endif

// *** verilog/spu_pkg.sv ***
package spu_pkg;
  typedef struct packed {
    logic sck_i;
    logic mosi_i;
    logic miso_i;
    logic nss_i;
  } spu_pin_in_s;
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic nss_o;
    logic nss_oe;
  } spu_pin_out_s;
  typedef enum logic [1:0] {
    SPU_IDLE, SPU_LEAD, SPU_TRAIL
  } spu_state_e;
endpackage

// *** verilog/spu_port.sv ***
`timescale 1ns/1ps
`include "spu_regs.svh"
module spu_port (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [4:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic                     wb_ack_o,
  output logic                     irq,
  input  wire spu_pkg::spu_pin_in_s  pin_in,
  output spu_pkg::spu_pin_out_s      pin_out
);
  import spu_pkg::*;

  // control: 7 done, 6 master, 5 mode error, 3:2 select mode, 0 enable
  logic [7:0]  ctrl;
  logic [7:0]  clkdiv;
  logic [7:0]  txbuf;
  logic        txfull;
  logic [7:0]  shreg;
  logic [7:0]  rxdata;
  logic [3:0]  bitcnt;
  logic [7:0]  divcnt;
  logic        sck_m;
  logic        miso_smp;
  logic [1:0]  irq_st;
  logic [1:0]  irq_en;
  spu_state_e  state;
  spu_pin_in_s s1;
  spu_pin_in_s s2;
  logic        sck_d;
  logic        nss_d;
  logic        ack_r;

  wire       enable   = ctrl[`SPU_BIT_ENABLE];
  wire       master   = ctrl[`SPU_BIT_MASTER_ENABLE_BIT];
  wire [1:0] selmode  = ctrl[3:2];
  wire       four_in  = selmode == 2'b01;
  wire       acc      = wb_cyc_i & wb_stb_i & ~ack_r & ce;
  wire       wr       = acc & wb_we_i & wb_sel_i[0];
  wire       wr_ctrl  = wr & (wb_adr_i == {1'b0, `SPU_ADDR_CTRL});
  wire       wr_data  = wr & (wb_adr_i == {1'b0, `SPU_ADDR_DATA});
  wire       wr_div   = wr & (wb_adr_i == {1'b0, `SPU_ADDR_CLKDIV});
  wire       wr_ien   = wr & (wb_adr_i == `SPU_ADDR_IRQEN);
  wire       wr_iclr  = wr & (wb_adr_i == `SPU_ADDR_IRQCLR);
  // three-wire slave always selected; low select enables slave
  wire       selected = (selmode == 2'b00) | (four_in & ~s2.nss_i);
  // serial clock seen only while selected
  wire       slv_act  = enable & ~master & selected;
  wire       sck_rise = slv_act & s2.sck_i & ~sck_d;
  wire       sck_fall = slv_act & ~s2.sck_i & sck_d;
  // falling select edge while master in mode 01
  wire       nss_fall = enable & master & four_in & nss_d & ~s2.nss_i;
  wire       tick     = divcnt == 8'h00;
  wire       m_busy   = state != SPU_IDLE;
  wire       m_start  = enable & master & ~m_busy & (txfull | wr_data);
  wire       last_bit = bitcnt == (`SPU_BITS - 4'h1);
  wire       m_done   = m_busy & tick & (state == SPU_TRAIL) & last_bit;
  wire       s_done   = sck_rise & last_bit;
  wire       done     = m_done | s_done;
  wire       s_load   = ~master & ~slv_act;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // select idles high so no false select fall follows reset
      s1    <= spu_pin_in_s'(4'h1);
      s2    <= spu_pin_in_s'(4'h1);
      sck_d <= 1'b0;
      nss_d <= 1'b1;
    end else if (ce) begin
      s1    <= pin_in;
      s2    <= s1;
      sck_d <= s2.sck_i;
      nss_d <= s2.nss_i;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= `SPU_CTRL_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl[6:0] <= wb_dat_i[6:0];
      end
      // lose master role on select fall
      if (nss_fall) begin
        ctrl[`SPU_BIT_MASTER_ENABLE_BIT]   <= 1'b0;
        ctrl[`SPU_BIT_MODEERR] <= 1'b1;
      end
      // done sets, only software zero clears; set wins
      if (done) begin
        ctrl[`SPU_BIT_DONE] <= 1'b1;
      end else if (wr_ctrl & ~wb_dat_i[`SPU_BIT_DONE]) begin
        ctrl[`SPU_BIT_DONE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkdiv <= `SPU_CLKDIV_RESET;
      irq_en <= 2'b00;
      irq_st <= 2'b00;
    end else if (ce) begin
      if (wr_div) begin
        clkdiv <= wb_dat_i[7:0];
      end
      if (wr_ien) begin
        irq_en <= wb_dat_i[1:0];
      end
      // sticky event bits, set wins over clear
      irq_st <= (irq_st & ~({2{wr_iclr}} & wb_dat_i[1:0]))
                | {nss_fall, done};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txbuf  <= 8'h00;
      txfull <= 1'b0;
    end else if (ce) begin
      if (wr_data) begin
        txbuf <= wb_dat_i[7:0];
      end
      if (m_start | (s_load & txfull)) begin
        txfull <= 1'b0;
      end else if (wr_data) begin
        txfull <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state  <= SPU_IDLE;
      shreg  <= 8'h00;
      rxdata <= 8'h00;
      bitcnt <= 4'h0;
      divcnt <= 8'h00;
      sck_m  <= 1'b0;
      miso_smp <= 1'b0;
    end else if (ce) begin
      divcnt <= (tick | ~m_busy) ? clkdiv : divcnt - 8'h01;
      unique case (state)
        SPU_IDLE: begin
          sck_m <= 1'b0;
          if (m_start) begin
            shreg  <= txfull ? txbuf : wb_dat_i[7:0];
            bitcnt <= 4'h0;
            state  <= SPU_LEAD;
          end else if (s_load) begin
            bitcnt <= 4'h0;
            if (txfull) begin
              shreg <= txbuf;
            end
          end else if (sck_rise) begin
            shreg  <= {shreg[6:0], s2.mosi_i};
            bitcnt <= last_bit ? 4'h0 : bitcnt + 4'h1;
            if (last_bit) begin
              rxdata <= {shreg[6:0], s2.mosi_i};
            end
          end
        end
        SPU_LEAD: begin
          if (~master | ~enable) begin
            state <= SPU_IDLE;
          end else if (tick) begin
            // sample slave-out on the rise, keep master-out steady
            sck_m    <= 1'b1;
            miso_smp <= s2.miso_i;
            state    <= SPU_TRAIL;
          end
        end
        SPU_TRAIL: begin
          if (~master | ~enable) begin
            state <= SPU_IDLE;
          end else if (tick) begin
            // shift on the fall so master-out never moves at a rise
            sck_m  <= 1'b0;
            shreg  <= {shreg[6:0], miso_smp};
            bitcnt <= last_bit ? 4'h0 : bitcnt + 4'h1;
            state  <= last_bit ? SPU_IDLE : SPU_LEAD;
            if (last_bit) begin
              rxdata <= {shreg[6:0], miso_smp};
            end
          end
        end
      endcase
    end
  end

  wire [7:0] stat_rd = {4'h0, s2.nss_i, txfull, m_busy, ~txfull};
  wire [7:0] rd_mux  =
    (wb_adr_i == {1'b0, `SPU_ADDR_CTRL})   ? ctrl   :
    (wb_adr_i == {1'b0, `SPU_ADDR_DATA})   ? rxdata :
    (wb_adr_i == {1'b0, `SPU_ADDR_CLKDIV}) ? clkdiv :
    (wb_adr_i == {1'b0, `SPU_ADDR_STAT})   ? stat_rd :
    (wb_adr_i == `SPU_ADDR_IRQST)          ? {6'h00, irq_st} :
    (wb_adr_i == `SPU_ADDR_IRQEN)          ? {6'h00, irq_en} : 8'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq      <= 1'b0;
    end else if (ce) begin
      ack_r    <= acc;
      wb_dat_o <= {24'h00_0000, rd_mux};
      irq      <= |(irq_st & irq_en);
    end
  end
  assign wb_ack_o = ack_r;

  // slave shifts on rising clock edge; slave-out is its register top bit
  wire slv_out_oe = enable & ~master & selected;
  always_comb begin
    pin_out = '0;
    // master drives master-out from shifter top bit
    pin_out.mosi_o  = shreg[7];
    pin_out.mosi_oe = enable & master;
    // serial clock driven only as master
    pin_out.sck_o   = sck_m;
    pin_out.sck_oe  = enable & master;
    pin_out.miso_o  = shreg[7];
    pin_out.miso_oe = slv_out_oe;
    // select pin driven only in mode 1x
    pin_out.nss_o   = ctrl[2];
    pin_out.nss_oe  = enable & selmode[1];
  end
  // sck_fall reserved for phase alignment; the shifter holds msb until rise
  wire unused_ok = sck_fall;
endmodule

// *** bench/spu_slave_model.sv ***
`timescale 1ns/1ps
module spu_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] sh = 8'h5A;
  always @(negedge sel_n) sh = tx;
  always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
  always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
  // released line shows the inverse, not a held value
  assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

// *** bench/spu_port_assertions.sv ***
`timescale 1ns/1ps
module spu_port_chk (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire logic [4:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_we_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic                 irq,
  input wire spu_pkg::spu_pin_out_s pin_out
);
  import spu_pkg::*;
  wire bus = wb_cyc_i && wb_stb_i;
  wire req = bus && ce && !wb_ack_o;
  wire done_rd = bus && wb_ack_o && !wb_we_i;
  wire mask_wr = bus && wb_ack_o && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == 5'h14 && wb_dat_i[7:0] == 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  ack_idle_a: assert property (!bus |=> !wb_ack_o) else $error("stray ack");
  unmapped_read_a: assert property (done_rd && wb_adr_i == 5'h1C
    |-> wb_dat_o == 32'h0) else $error("unmapped data");
  master_clock_a: assert property (pin_out.mosi_oe |-> pin_out.sck_oe)
    else $error("master without clock");
  pin_roles_a: assert property (pin_out.mosi_oe |-> !pin_out.miso_oe)
    else $error("both data lines driven");
  bit_hold_a: assert property (pin_out.mosi_oe && pin_out.sck_o
    && $past(pin_out.sck_o) |-> $stable(pin_out.mosi_o)) else $error("bit moved");
  irq_mask_a: assert property (mask_wr |-> ##2 !irq)
    else $error("masked irq high");
  cover property ($rose(irq));
  cover property ($rose(pin_out.sck_o));
  cover property (pin_out.miso_oe);
endmodule
bind spu_port spu_port_chk chk (.clk_sys, .rst, .ce, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq,
  .pin_out);

// *** bench/tb_spu_port.sv ***
`timescale 1ns/1ps
module tb_spu_port;
  import spu_pkg::*;
  typedef struct packed {
    logic [4:0] a;
    logic       w;
    logic [7:0] d;
    logic [7:0] e;
    logic       n;
    logic [3:0] p;
  } spu_row_s;
  logic         clk_sys, rst, cyc, stb, we, bsck, bmosi, bnss, smiso;
  logic         wb_ack_o, irq;
  logic [4:0]   adr;
  logic [31:0]  dat, rd, wb_dat_o;
  logic [7:0]   srx;
  logic [7:0]   stx = 8'h3C;
  logic [7:0]   sb = 8'h96;
  int           miscompares, cmp_count, cycles, edges;
  spu_pin_in_s  pin_in;
  spu_pin_out_s pin_out;
  spu_row_s     rows [15];
  assign pin_in.sck_i = pin_out.sck_oe ? pin_out.sck_o : bsck;
  assign pin_in.mosi_i = pin_out.mosi_oe ? pin_out.mosi_o : bmosi;
  assign pin_in.miso_i = pin_out.miso_oe ? pin_out.miso_o : smiso;
  assign pin_in.nss_i = pin_out.nss_oe ? pin_out.nss_o : bnss;
  spu_port uut (.clk_sys, .rst, .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o, .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o, .irq, .pin_in, .pin_out);
  spu_slave_model far (.sck(pin_in.sck_i), .mosi(pin_in.mosi_i),
    .sel_n(pin_in.nss_i), .tx(stx), .miso(smiso), .rx(srx));
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("unexpected %s exp %h got %h", s, x, g);
      miscompares++;
    end
  endtask
  task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    adr <= a;
    we <= w;
    dat <= {24'h000000, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 40);
    rd = wb_dat_o;
    if (t == 40) miscompares++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic irq_step(input logic [4:0] a, input logic [7:0] d,
                          input logic e);
    wb(a, 1'b1, d);
    repeat (3) @(posedge clk_sys);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge pin_out.sck_o) edges++;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, bsck, bmosi, bnss} = 6'h01;
    adr = 5'h00;
    dat = 32'h0;
    rows = '{{5'h00,1'h0,8'h00,8'h04,1'h1,4'h0},
      {5'h08,1'h0,8'h00,8'h01,1'h1,4'h0}, {5'h10,1'h0,8'h00,8'h00,1'h1,4'h0},
      {5'h1C,1'h1,8'hFF,8'h00,1'h1,4'h0}, {5'h1C,1'h0,8'h00,8'h00,1'h1,4'h0},
      {5'h00,1'h1,8'h01,8'h00,1'h1,4'h4}, {5'h00,1'h1,8'h05,8'h00,1'h1,4'h0},
      {5'h00,1'h1,8'h05,8'h00,1'h0,4'h4}, {5'h00,1'h1,8'h45,8'h00,1'h1,4'h8},
      {5'h00,1'h1,8'h45,8'h00,1'h0,4'h4}, {5'h00,1'h0,8'h00,8'h25,1'h0,4'h4},
      {5'h00,1'h1,8'h4D,8'h00,1'h1,4'hB}, {5'h14,1'h1,8'h01,8'h00,1'h1,4'hB},
      {5'h14,1'h0,8'h00,8'h01,1'h1,4'hB}, {5'h00,1'h1,8'h49,8'h00,1'h1,4'hA}};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      bnss <= rows[i].n;
      wb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("read", rows[i].e, rd[7:0]);
      repeat (5) @(posedge clk_sys);
      chk("pins", {4'h0, rows[i].p}, {4'h0, pin_out.mosi_oe, pin_out.miso_oe,
        pin_out.nss_oe, pin_out.nss_oe & pin_out.nss_o});
    end
    wb(5'h08, 1'b1, 8'h04);
    edges = 0;
    wb(5'h04, 1'b1, 8'hA5);
    for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk_sys);
    chk("far rx", 8'hA5, srx);
    chk("edges", 8'h08, edges[7:0]);
    wb(5'h04, 1'b0, 8'h00);
    chk("data", 8'h3C, rd[7:0]);
    wb(5'h00, 1'b0, 8'h00);
    chk("done", 8'h80, rd[7:0] & 8'h80);
    irq_step(5'h14, 8'h00, 1'b0);
    irq_step(5'h14, 8'h01, 1'b1);
    irq_step(5'h18, 8'h01, 1'b0);
    wb(5'h00, 1'b1, 8'h01);
    wb(5'h00, 1'b0, 8'h00);
    chk("cleared", 8'h00, rd[7:0] & 8'h80);
    for (int i = 7; i >= 0; i--) begin
      bmosi <= sb[i];
      repeat (4) @(posedge clk_sys);
      bsck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bsck <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    wb(5'h04, 1'b0, 8'h00);
    chk("slave rx", 8'h96, rd[7:0]);
    wrap_up();
  end
endmodule
